// ==== hw/cpu_power_mode_control.v ====
// Function
// - Idle entered only after the writing instruction completes; processor halts.
// - In idle, contents kept; clocks and peripherals keep running.
// - Enabled interrupt in idle clears idle bit and restarts processor.
// - After interrupt return, execution resumes after the idle-setting instruction.
// - Reset ending idle runs normal reset sequence from address zero.
// - Enabled watchdog keeps counting in idle; expiry resets and ends idle.
// - Stop after writing instruction: halt oscillator, processor, digital peripherals.
// - In stop, only clock-loss detector active; analog enables unchanged.
// - Stop exits only by reset, then fetch from zero; interrupts ignored.
// - Enabled clock-loss detector resets after 100 us, ending stop.
// - Program and data spaces overlap; instruction type selects space.
// - 8 kB variant flash 0 to 0x1fff, above 0x1dff reserved.
// - 4 kB flash ends 0x0fff, 2 kB flash ends 0x07ff.
// - Program memory read-only unless store write enable set; then writes redirect.
`timescale 1ns/10ps
`default_nettype none
`include "power_mode_consts.vh"
module cpu_power_mode_control #(
  parameter [31:0] CLOCK_LOSS_CYCLES = `CLOCK_LOSS_CYCLES,
  parameter [1:0] VARIANT = `VARIANT_8K
) (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Special register port
  input wire sfr_wr_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  output reg [7:0] sfr_rdata_o,
  // Processor hooks
  input wire instr_done_i,
  input wire irq_pending_i,
  input wire watchdog_expire_i,
  input wire clock_loss_en_i,
  input wire ext_reset_i,
  output reg cpu_halt_o,
  output reg periph_clk_en_o,
  output reg int_osc_en_o,
  output reg irq_service_o,
  output reg core_reset_o,
  output reg [15:0] fetch_vector_o,
  // Memory access
  input wire mem_req_i,
  input wire mem_is_code_i,
  input wire mem_wr_i,
  input wire [15:0] mem_addr_i,
  output reg code_sel_o,
  output reg code_wr_o,
  output reg mem_reserved_o
);
  // ****************************************
  // States
  // ****************************************
  localparam [2:0] ST_RUN = 3'b001;
  localparam [2:0] ST_IDLE = 3'b010;
  localparam [2:0] ST_STOP = 3'b100;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] power_mode_ctrl_r;
  reg [7:0] program_store_ctrl_r;
  reg [7:0] arith_working_reg_r;
  reg idle_req_r;
  reg stop_req_r;
  reg [31:0] loss_cnt_r;
  reg [2:0] ext_sync_r;
  reg ext_rst_r;
  wire ext_rst = ext_rst_r;
  wire loss_fire = clock_loss_en_i && (loss_cnt_r >= CLOCK_LOSS_CYCLES - 32'd1);
  wire wr_power_mode_ctrl = sfr_wr_i && (sfr_addr_i == `POWER_MODE_CTRL_ADDR);
  // ****************************************
  // Internal reset sources
  // ****************************************
  wire watchdog_rst = watchdog_expire_i && (state_r != ST_STOP);
  wire loss_rst = loss_fire && (state_r == ST_STOP);
  wire any_rst = ext_rst | watchdog_rst | loss_rst;
  // ****************************************
  // External reset synchroniser
  // ****************************************
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ext_sync_r <= 3'h0;
      ext_rst_r <= 1'h0;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], ext_reset_i};
      // Level taken once second and third stages agree
      if (ext_sync_r[1] == ext_sync_r[2]) begin
        ext_rst_r <= ext_sync_r[2];
      end
    end
  end
  // ****************************************
  // State machine
  // ****************************************
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (stop_req_r && instr_done_i) begin
          state_nxt = ST_STOP;
        end else if (idle_req_r && instr_done_i) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (irq_pending_i) begin
          state_nxt = ST_RUN;
        end
      end
      ST_STOP: begin
        state_nxt = ST_STOP;
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
    if (any_rst) begin
      state_nxt = ST_RUN;
    end
  end
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end
  // ****************************************
  // Mode outputs
  // ****************************************
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cpu_halt_o <= 1'h0;
      periph_clk_en_o <= 1'h1;
      int_osc_en_o <= 1'h1;
      irq_service_o <= 1'h0;
      core_reset_o <= 1'h0;
      fetch_vector_o <= `RESET_VECTOR;
    end else begin
      core_reset_o <= any_rst;
      fetch_vector_o <= `RESET_VECTOR;
      irq_service_o <= (state_r == ST_IDLE) && irq_pending_i && !any_rst;
      cpu_halt_o <= (state_nxt != ST_RUN);
      periph_clk_en_o <= (state_nxt != ST_STOP);
      int_osc_en_o <= (state_nxt != ST_STOP);
    end
  end
  // ****************************************
  // Clock-loss counter
  // ****************************************
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      loss_cnt_r <= 32'h0;
    end else if (state_r == ST_STOP && clock_loss_en_i && !loss_fire) begin
      loss_cnt_r <= loss_cnt_r + 32'h1;
    end else begin
      loss_cnt_r <= 32'h0;
    end
  end
  // ****************************************
  // Control registers
  // ****************************************
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      power_mode_ctrl_r <= `POWER_MODE_CTRL_RST;
      program_store_ctrl_r <= `PROGRAM_STORE_CTRL_RST;
      arith_working_reg_r <= `ARITH_WORKING_REG_RST;
      idle_req_r <= 1'h0;
      stop_req_r <= 1'h0;
    end else if (any_rst) begin
      power_mode_ctrl_r <= `POWER_MODE_CTRL_RST;
      program_store_ctrl_r <= `PROGRAM_STORE_CTRL_RST;
      idle_req_r <= 1'h0;
      stop_req_r <= 1'h0;
    end else begin
      if (wr_power_mode_ctrl) begin
        power_mode_ctrl_r <= {6'h00, sfr_wdata_i[`STOP_SEL_BIT], sfr_wdata_i[`IDLE_SEL_BIT]};
        idle_req_r <= sfr_wdata_i[`IDLE_SEL_BIT];
        stop_req_r <= sfr_wdata_i[`STOP_SEL_BIT];
      end else if (state_r == ST_RUN && instr_done_i) begin
        idle_req_r <= 1'h0;
        stop_req_r <= 1'h0;
      end
      if (state_r == ST_IDLE && irq_pending_i) begin
        power_mode_ctrl_r[`IDLE_SEL_BIT] <= 1'h0;
      end
      if (sfr_wr_i && sfr_addr_i == `PROGRAM_STORE_CTRL_ADDR) begin
        program_store_ctrl_r <= {7'h00, sfr_wdata_i[`PS_WRITE_EN_BIT]};
      end
      if (sfr_wr_i && sfr_addr_i == `ARITH_WORKING_REG_ADDR) begin
        arith_working_reg_r <= sfr_wdata_i;
      end
    end
  end
  // ****************************************
  // Register read
  // ****************************************
  always @* begin
    case (sfr_addr_i)
      `POWER_MODE_CTRL_ADDR: sfr_rdata_o = {6'h00, power_mode_ctrl_r[1:0]};
      `PROGRAM_STORE_CTRL_ADDR: sfr_rdata_o = program_store_ctrl_r;
      `ARITH_WORKING_REG_ADDR: sfr_rdata_o = arith_working_reg_r;
      default: sfr_rdata_o = 8'h00;
    endcase
  end
  // ****************************************
  // Program memory map
  // ****************************************
  reg [15:0] flash_end;
  always @* begin
    case (VARIANT)
      `VARIANT_4K: flash_end = `FLASH_END_4K;
      `VARIANT_2K: flash_end = `FLASH_END_2K;
      default: flash_end = `FLASH_RESERVED_ABOVE_8K;
    endcase
  end
  // ****************************************
  // Access decode
  // ****************************************
  wire ps_wen = program_store_ctrl_r[`PS_WRITE_EN_BIT];
  always @* begin
    code_sel_o = mem_req_i && (mem_is_code_i || (mem_wr_i && ps_wen));
    code_wr_o = mem_req_i && mem_wr_i && !mem_is_code_i && ps_wen;
    mem_reserved_o = code_sel_o && (mem_addr_i > flash_end);
  end
endmodule
`default_nettype wire

// ==== hw/power_mode_consts.vh ====
`ifndef POWER_MODE_CONSTS_VH
`define POWER_MODE_CONSTS_VH
// ****************************************
// Register addresses
// ****************************************
`define POWER_MODE_CTRL_ADDR 8'h87
`define PROGRAM_STORE_CTRL_ADDR 8'h8f
`define ARITH_WORKING_REG_ADDR 8'he0
// ****************************************
// Field positions and reset values
// ****************************************
`define IDLE_SEL_BIT 0
`define STOP_SEL_BIT 1
`define PS_WRITE_EN_BIT 0
`define POWER_MODE_CTRL_RST 8'h00
`define PROGRAM_STORE_CTRL_RST 8'h00
`define ARITH_WORKING_REG_RST 8'h00
`define RESET_VECTOR 16'h0000
// ****************************************
// Program memory map
// ****************************************
`define FLASH_END_8K 16'h1fff
`define FLASH_RESERVED_ABOVE_8K 16'h1dff
`define FLASH_END_4K 16'h0fff
`define FLASH_END_2K 16'h07ff
`define VARIANT_8K 2'h0
`define VARIANT_4K 2'h1
`define VARIANT_2K 2'h2
// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 50
`define CLOCK_LOSS_TIMEOUT_US 100
`define CLOCK_LOSS_CYCLES ((`CLOCK_LOSS_TIMEOUT_US * 1000) / `CLK_PERIOD_NS)
`endif

// ==== verification/cpu_power_mode_control_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module pmc_chk #(
  parameter [31:0] CLOCK_LOSS_CYCLES = 32'h8,
  parameter [1:0] VARIANT = 2'h0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Processor hooks
  input wire logic instr_done_i,
  input wire logic irq_pending_i,
  input wire logic watchdog_expire_i,
  input wire logic cpu_halt_o,
  input wire logic periph_clk_en_o,
  input wire logic int_osc_en_o,
  input wire logic irq_service_o,
  input wire logic core_reset_o,
  input wire logic [15:0] fetch_vector_o,
  // Memory access
  input wire logic mem_req_i,
  input wire logic mem_is_code_i,
  input wire logic mem_wr_i,
  input wire logic code_sel_o,
  input wire logic code_wr_o,
  input wire logic mem_reserved_o,
  input wire logic [15:0] mem_addr_i
);
  localparam [15:0] LIM = (VARIANT == 2'h0) ? 16'h1dff : (VARIANT == 2'h1) ? 16'h0fff : 16'h07ff;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire idle_w = cpu_halt_o && int_osc_en_o;
  a_halt_cause: assert property ($rose(cpu_halt_o) |-> $past(instr_done_i))
    else $error("halt without finished instruction");
  a_idle_clocks: assert property (idle_w |-> periph_clk_en_o)
    else $error("clocks stopped in idle");
  a_idle_wake: assert property (idle_w && irq_pending_i |=>
    !cpu_halt_o && irq_service_o)
    else $error("interrupt did not end idle");
  a_reset_vector: assert property (fetch_vector_o == 16'h0000 &&
    (!core_reset_o || !cpu_halt_o))
    else $error("fetch vector not zero");
  a_wdog_reset: assert property (idle_w && watchdog_expire_i |=> core_reset_o)
    else $error("watchdog did not reset");
  a_stop_clocks: assert property (!int_osc_en_o |-> cpu_halt_o && !periph_clk_en_o)
    else $error("stop state inconsistent");
  a_stop_deaf: assert property (!int_osc_en_o |=> !irq_service_o)
    else $error("interrupt served in stop");
  a_code_sel: assert property (mem_req_i && mem_is_code_i |-> code_sel_o)
    else $error("code access not in program space");
  a_flash_map: assert property (mem_req_i && mem_is_code_i |->
    mem_reserved_o == (mem_addr_i > LIM))
    else $error("reserved flag wrong");
  a_read_only: assert property (mem_req_i && !mem_wr_i |-> !code_wr_o)
    else $error("program write on a read");
  c_idle_wake: cover property (idle_w && irq_pending_i);
  c_stop: cover property ($fell(int_osc_en_o));
  c_wdog: cover property (idle_w && watchdog_expire_i);
  c_resv: cover property (mem_req_i && mem_reserved_o);
endmodule
`default_nettype wire

// ==== verification/cpu_power_mode_control_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module cpu_power_mode_control_tb_top;
  localparam [31:0] CLS = 32'd8;
  logic clk_i = 0, reset_i = 1, sfr_wr_i = 0, instr_done_i = 0, irq_pending_i = 0;
  logic watchdog_expire_i = 0, clock_loss_en_i = 0, ext_reset_i = 0;
  logic mem_req_i = 0, mem_is_code_i = 0, mem_wr_i = 0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00;
  logic [15:0] mem_addr_i = 16'h0000;
  wire [7:0] sfr_rdata_o;
  wire [15:0] fetch_vector_o;
  wire cpu_halt_o, periph_clk_en_o, int_osc_en_o, irq_service_o, core_reset_o;
  wire code_sel_o, code_wr_o, mem_reserved_o;
  int error_cnt = 0, cmp_count = 0, cyc = 0, ps_m, i, n;
  logic c, w;
  cpu_power_mode_control #(.CLOCK_LOSS_CYCLES(CLS), .VARIANT(2'h0)) i_dut (.clk_i(clk_i),
    .reset_i(reset_i), .sfr_wr_i(sfr_wr_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .instr_done_i(instr_done_i), .irq_pending_i(irq_pending_i),
    .watchdog_expire_i(watchdog_expire_i), .clock_loss_en_i(clock_loss_en_i),
    .ext_reset_i(ext_reset_i), .cpu_halt_o(cpu_halt_o), .periph_clk_en_o(periph_clk_en_o),
    .int_osc_en_o(int_osc_en_o), .irq_service_o(irq_service_o), .core_reset_o(core_reset_o),
    .fetch_vector_o(fetch_vector_o), .mem_req_i(mem_req_i), .mem_is_code_i(mem_is_code_i),
    .mem_wr_i(mem_wr_i), .mem_addr_i(mem_addr_i), .code_sel_o(code_sel_o),
    .code_wr_o(code_wr_o), .mem_reserved_o(mem_reserved_o));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic step(input int k = 1);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1;
    step();
    sfr_wr_i = 0;
    step();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i = a;
    #1 chk(sfr_rdata_o, d);
    step();
  endtask
  task automatic st(input logic h, input logic k, input logic o);
    chk({cpu_halt_o, periph_clk_en_o, int_osc_en_o}, {h, k, o});
  endtask
  task automatic go();
    instr_done_i = 1;
    step();
    instr_done_i = 0;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    n = $urandom(14618);
    step(5);
    reset_i = 0;
    rd(8'h87, 8'h00); rd(8'h8f, 8'h00); rd(8'h80, 8'h00); st(0, 1, 1);
    chk(fetch_vector_o, 16'h0000);
    n = $urandom_range(255);
    wr(8'he0, n[7:0]);
    $display("test registers done");
    wr(8'h87, 8'h01); st(0, 1, 1); rd(8'h87, 8'h01);
    go(); st(1, 1, 1);
    irq_pending_i = 1;
    step(); chk(irq_service_o, 1); st(0, 1, 1);
    irq_pending_i = 0;
    rd(8'h87, 8'h00); rd(8'he0, n[7:0]);
    wr(8'h87, 8'h01); go();
    watchdog_expire_i = 1;
    step(); chk(core_reset_o, 1);
    watchdog_expire_i = 0;
    step(2); st(0, 1, 1); rd(8'h87, 8'h00);
    $display("test idle done");
    wr(8'h87, 8'h02); go(); st(1, 0, 0);
    irq_pending_i = 1;
    step(3); chk(irq_service_o, 0); st(1, 0, 0);
    irq_pending_i = 0;
    clock_loss_en_i = 1;
    for (i = 0; i < 40 && core_reset_o !== 1'b1; i++) step();
    chk(16'(i), CLS[15:0]);
    clock_loss_en_i = 0;
    step(2); st(0, 1, 1); rd(8'h87, 8'h00);
    wr(8'h87, 8'h03); go(); st(1, 0, 0);
    ext_reset_i = 1;
    step(6); chk(core_reset_o, 1);
    ext_reset_i = 0;
    step(6); st(0, 1, 1); rd(8'h87, 8'h00);
    wr(8'h87, 8'h01); go(); st(1, 1, 1);
    ext_reset_i = 1;
    step(6); chk(core_reset_o, 1);
    ext_reset_i = 0;
    step(6); st(0, 1, 1); rd(8'h87, 8'h00);
    $display("test stop done");
    wr(8'h8f, 8'h01); rd(8'h8f, 8'h01);
    for (i = 0; i < 40; i++) begin
      if (i == 20) wr(8'h8f, 8'h00);
      ps_m = (i < 20);
      c = 1'($urandom);
      w = 1'($urandom);
      mem_req_i = 1; mem_is_code_i = c; mem_wr_i = w;
      mem_addr_i = (i % 4 == 0) ? 16'h1dff : (i % 4 == 1) ? 16'h1e00 : 16'($urandom);
      #1 chk(code_wr_o, !c && w && ps_m);
      chk(code_sel_o, c || (w && ps_m));
      chk(mem_reserved_o, (c || (w && ps_m)) && mem_addr_i > 16'h1dff);
      step();
    end
    mem_req_i = 0;
    $display("test memory done");
    results();
  end
endmodule
bind cpu_power_mode_control pmc_chk #(.CLOCK_LOSS_CYCLES(CLOCK_LOSS_CYCLES), .VARIANT(VARIANT))
  u_chk (.clk_i(clk_i), .reset_i(reset_i), .instr_done_i(instr_done_i),
  .irq_pending_i(irq_pending_i), .watchdog_expire_i(watchdog_expire_i), .cpu_halt_o(cpu_halt_o),
  .periph_clk_en_o(periph_clk_en_o), .int_osc_en_o(int_osc_en_o), .irq_service_o(irq_service_o),
  .core_reset_o(core_reset_o), .fetch_vector_o(fetch_vector_o), .mem_req_i(mem_req_i),
  .mem_is_code_i(mem_is_code_i), .mem_wr_i(mem_wr_i), .code_sel_o(code_sel_o),
  .code_wr_o(code_wr_o), .mem_reserved_o(mem_reserved_o), .mem_addr_i(mem_addr_i));
`default_nettype wire
